// *** verilog/cars_cfg.svh ***
`ifndef CARS_CFG_SVH
`define CARS_CFG_SVH

// Special-register numbers decoded by the move instructions
`define CARS_SREG_IES 10'h001
`define CARS_SREG_LINK 10'h008
`define CARS_SREG_LOOP 10'h009
`define CARS_SREG_SAVE 10'h01B
`define CARS_SREG_TLO_RD 10'h10C
`define CARS_SREG_THI_RD 10'h10D
`define CARS_SREG_TLO_WR 10'h11C
`define CARS_SREG_THI_WR 10'h11D
`define CARS_SREG_IMPL0 10'h3F0

// Implemented storage of the integer exception status word
`define CARS_IES_MASK 32'hE000FF7F
`define CARS_IES_SUM 31
`define CARS_IES_OVF 30
`define CARS_IES_CARRY 29

// Machine-state word fields (bit n of the word sits at [31-n])
`define CARS_MSW_LOWE 18
`define CARS_MSW_AIE 15
`define CARS_MSW_USER 14
`define CARS_MSW_MARK 2

// Low-power selection bits of implementation control 0
`define CARS_IMPL_DOZE 23
`define CARS_IMPL_NAP 22
`define CARS_IMPL_SLEEP 21

// Reset values
`define CARS_MSW_RST 32'h00000000
`define CARS_IMPL0_RST 32'h00000000
`define CARS_WORD_RST 32'h00000000

`endif

// *** verilog/cars_pkg.sv ***
package cars_pkg;

   // Which special register a move instruction selects
   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_IES,
      SEL_LINK,
      SEL_LOOP,
      SEL_SAVE,
      SEL_TLO,
      SEL_THI,
      SEL_IMPL0
   } cars_sel_e;

   // Power state of the core
   typedef enum logic [1:0] {
      PWR_FULL,
      PWR_DOZE,
      PWR_NAP,
      PWR_SLEEP
   } cars_pwr_e;

endpackage : cars_pkg

// *** verilog/cars_timebase.sv ***
`timescale 1ns/1ps
`include "cars_cfg.svh"

// Two-half time base; a write to a half takes precedence over the tick
module cars_timebase #(
   parameter int W = 32
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] lo_q,
   output logic [W-1:0] hi_q
);

   logic carry;

   // Upper half steps when a tick finds the lower half all ones, even if a write to it lands then
   assign carry = tick && (lo_q == {W{1'b1}});

   // Lower half
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         lo_q <= '0;
      end else if (wr_lo) begin
         lo_q <= wdata;
      end else if (tick) begin
         lo_q <= lo_q + W'(1);
      end
   end

   // Upper half
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hi_q <= '0;
      end else if (wr_hi) begin
         hi_q <= wdata;
      end else if (carry) begin
         hi_q <= hi_q + W'(1);
      end
   end

endmodule : cars_timebase

// *** verilog/cars_regset.sv ***
`timescale 1ns/1ps
`include "cars_cfg.svh"

// Overview of operation
// - Unknown special-register numbers raise illegal instruction
// - Integer exception status is special register 1
// - Status bits 16 to 23 are real storage
// - Thirty-two general registers for integer and addressing
// - Thirty-two floating registers for floating instructions
// - Condition word is eight independent 4-bit fields
// - Time base halves: supervisor write, anyone reads
// - State word changes only by move, call, return, exception, wake
// - Exceptions copy the state word to saved state
// - Low-energy bit gates entry to power saving
// - Doze, nap, sleep bits choose the power state
// - Waking from power saving clears low-energy bit
// - Marked-process bit tells monitor to count
// - Async enable gates all five exception sources
// - User registers need no supervisor privilege
// - Link register feeds branch target, captures return
// - Loop count decrements and feeds branch target
// - Memory moves only through load and store
// - Destination may differ from both sources
module cars_regset #(
   parameter int GW = 32,
   parameter int FW = 64,
   parameter int NREG = 32
) (
   input wire logic core_clk,
   input wire logic rstn,
   // General registers: two reads, one write
   input wire logic [4:0] gen_ra,
   input wire logic [4:0] gen_rb,
   input wire logic gen_we,
   input wire logic [4:0] gen_rd,
   input wire logic [GW-1:0] gen_wdata,
   output logic [GW-1:0] gen_a_q,
   output logic [GW-1:0] gen_b_q,
   // Floating registers: two reads, one write
   input wire logic [4:0] flt_ra,
   input wire logic [4:0] flt_rb,
   input wire logic flt_we,
   input wire logic [4:0] flt_rd,
   input wire logic [FW-1:0] flt_wdata,
   output logic [FW-1:0] flt_a_q,
   output logic [FW-1:0] flt_b_q,
   // Condition fields
   input wire logic cond_we,
   input wire logic [2:0] cond_fld,
   input wire logic [3:0] cond_val,
   input wire logic [4:0] cond_bit_sel,
   output logic [31:0] cond_q,
   output logic cond_bit_q,
   // Integer exception status updates from arithmetic
   input wire logic ies_ca_we,
   input wire logic ies_ca_val,
   input wire logic ies_ov_we,
   input wire logic ies_ov_val,
   output logic [31:0] ies_q,
   // Link and loop count
   input wire logic link_we,
   input wire logic [31:0] link_addr,
   input wire logic loop_dec,
   output logic [31:0] link_q,
   output logic [31:0] loop_q,
   // Special-register moves
   input wire logic sreg_req,
   input wire logic sreg_wr,
   input wire logic [9:0] sreg_num,
   input wire logic [31:0] sreg_wdata,
   output logic sreg_done_q,
   output logic [31:0] sreg_rdata_q,
   output logic sreg_illegal_q,
   output logic sreg_priv_q,
   // State word changes
   input wire logic msw_wr,
   input wire logic [31:0] msw_wdata,
   input wire logic exc_take,
   input wire logic call_take,
   input wire logic ret_exec,
   output logic [31:0] msw_q,
   output logic [31:0] save_q,
   // Time base
   input wire logic tb_tick,
   output logic [31:0] time_lower_q,
   output logic [31:0] time_upper_q,
   // Power and events
   input wire logic pwr_idle,
   input wire logic wake_evt,
   output cars_pkg::cars_pwr_e pwr_state_q,
   output logic mark_count_q,
   input wire logic [4:0] async_src,
   output logic [4:0] async_take_q
);

   logic [GW-1:0] gen_mem [NREG];
   logic [FW-1:0] flt_mem [NREG];
   logic [31:0] impl0_q;
   cars_pkg::cars_sel_e sel;
   logic user_mode;
   logic sreg_ok;
   logic wr_ok;
   logic any_exc;
   logic wake_now;

   // Full decode of the number; read-only and write-only numbers differ
   function automatic cars_pkg::cars_sel_e sreg_decode(
      input logic [9:0] n,
      input logic wr
   );
      cars_pkg::cars_sel_e s;
      s = cars_pkg::SEL_NONE;
      if (n == `CARS_SREG_IES) begin
         s = cars_pkg::SEL_IES;
      end else if (n == `CARS_SREG_LINK) begin
         s = cars_pkg::SEL_LINK;
      end else if (n == `CARS_SREG_LOOP) begin
         s = cars_pkg::SEL_LOOP;
      end else if (n == `CARS_SREG_SAVE) begin
         s = cars_pkg::SEL_SAVE;
      end else if (n == `CARS_SREG_IMPL0) begin
         s = cars_pkg::SEL_IMPL0;
      end else if (!wr && n == `CARS_SREG_TLO_RD) begin
         s = cars_pkg::SEL_TLO;
      end else if (!wr && n == `CARS_SREG_THI_RD) begin
         s = cars_pkg::SEL_THI;
      end else if (wr && n == `CARS_SREG_TLO_WR) begin
         s = cars_pkg::SEL_TLO;
      end else if (wr && n == `CARS_SREG_THI_WR) begin
         s = cars_pkg::SEL_THI;
      end
      return s;
   endfunction : sreg_decode

   // Access checks: user-level registers need no privilege
   always_comb begin
      sel = sreg_decode(sreg_num, sreg_wr);
      user_mode = msw_q[`CARS_MSW_USER];
      sreg_ok = 1'b1;
      if (sel == cars_pkg::SEL_NONE) begin
         sreg_ok = 1'b0;
      end else if (user_mode && (sel == cars_pkg::SEL_SAVE ||
                   sel == cars_pkg::SEL_IMPL0)) begin
         sreg_ok = 1'b0;
      end else if (user_mode && sreg_wr &&
                   (sel == cars_pkg::SEL_TLO ||
                    sel == cars_pkg::SEL_THI)) begin
         sreg_ok = 1'b0;
      end
      wr_ok = sreg_req && sreg_wr && sreg_ok;
      any_exc = exc_take || call_take;
      wake_now = (pwr_state_q != cars_pkg::PWR_FULL) && wake_evt;
   end

   // General registers: write port independent of both reads
   always_ff @(posedge core_clk) begin
      if (gen_we) begin
         gen_mem[gen_rd] <= gen_wdata;
      end
   end

   // Registered reads see the old value on a same-cycle write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         gen_a_q <= '0;
         gen_b_q <= '0;
      end else begin
         gen_a_q <= gen_mem[gen_ra];
         gen_b_q <= gen_mem[gen_rb];
      end
   end

   // Floating registers, same structure at the wider width
   always_ff @(posedge core_clk) begin
      if (flt_we) begin
         flt_mem[flt_rd] <= flt_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         flt_a_q <= '0;
         flt_b_q <= '0;
      end else begin
         flt_a_q <= flt_mem[flt_ra];
         flt_b_q <= flt_mem[flt_rb];
      end
   end

   // Condition word: field n occupies bits 4n..4n+3 from the top
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cond_q <= `CARS_WORD_RST;
         cond_bit_q <= 1'b0;
      end else begin
         if (cond_we) begin
            cond_q[5'(31 - 4 * cond_fld) -: 4] <= cond_val;
         end
         cond_bit_q <= cond_q[5'(31 - cond_bit_sel)];
      end
   end

   // Integer exception status; arithmetic updates follow a move
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ies_q <= `CARS_WORD_RST;
      end else begin
         if (wr_ok && sel == cars_pkg::SEL_IES) begin
            ies_q <= sreg_wdata & `CARS_IES_MASK;
         end
         if (ies_ca_we) begin
            ies_q[`CARS_IES_CARRY] <= ies_ca_val;
         end
         if (ies_ov_we) begin
            ies_q[`CARS_IES_OVF] <= ies_ov_val;
            if (ies_ov_val) begin
               ies_q[`CARS_IES_SUM] <= 1'b1; // Summary is sticky
            end
         end
      end
   end

   // Link register: a branch-and-link capture beats a move
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         link_q <= `CARS_WORD_RST;
      end else if (link_we) begin
         link_q <= link_addr;
      end else if (wr_ok && sel == cars_pkg::SEL_LINK) begin
         link_q <= sreg_wdata;
      end
   end

   // Loop count: a move beats the branch decrement
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         loop_q <= `CARS_WORD_RST;
      end else if (wr_ok && sel == cars_pkg::SEL_LOOP) begin
         loop_q <= sreg_wdata;
      end else if (loop_dec) begin
         loop_q <= loop_q - 32'h00000001;
      end
   end

   // Implementation control 0 holds the power-mode selection
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         impl0_q <= `CARS_IMPL0_RST;
      end else if (wr_ok && sel == cars_pkg::SEL_IMPL0) begin
         impl0_q <= sreg_wdata;
      end
   end

   // Saved state: exceptions take priority over a move
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         save_q <= `CARS_WORD_RST;
      end else if (any_exc) begin
         save_q <= msw_q;
      end else if (wr_ok && sel == cars_pkg::SEL_SAVE) begin
         save_q <= sreg_wdata;
      end
   end

   // State word: only move-to-state, call, return, exceptions and wake
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         msw_q <= `CARS_MSW_RST;
      end else if (any_exc) begin
         msw_q[`CARS_MSW_AIE] <= 1'b0;
         msw_q[`CARS_MSW_USER] <= 1'b0;
         msw_q[`CARS_MSW_LOWE] <= 1'b0;
      end else if (ret_exec) begin
         msw_q <= save_q;
      end else if (msw_wr && !msw_q[`CARS_MSW_USER]) begin
         msw_q <= msw_wdata;
      end else if (wake_now) begin
         msw_q[`CARS_MSW_LOWE] <= 1'b0;
      end
   end

   // Time base halves behind the move instructions
   cars_timebase #(
      .W(32)
   ) cars_timebase_inst (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tb_tick),
      .wr_lo(wr_ok && sel == cars_pkg::SEL_TLO),
      .wr_hi(wr_ok && sel == cars_pkg::SEL_THI),
      .wdata(sreg_wdata),
      .lo_q(time_lower_q),
      .hi_q(time_upper_q)
   );

   // Move answer one cycle after the request
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sreg_done_q <= 1'b0;
         sreg_illegal_q <= 1'b0;
         sreg_priv_q <= 1'b0;
         sreg_rdata_q <= `CARS_WORD_RST;
      end else begin
         sreg_done_q <= sreg_req || msw_wr;
         sreg_illegal_q <= sreg_req && sel == cars_pkg::SEL_NONE;
         sreg_priv_q <= (sreg_req && sel != cars_pkg::SEL_NONE &&
                         !sreg_ok) ||
                        (msw_wr && msw_q[`CARS_MSW_USER]);
         sreg_rdata_q <= `CARS_WORD_RST;
         if (sreg_req && !sreg_wr && sreg_ok) begin
            case (sel)
               cars_pkg::SEL_IES: sreg_rdata_q <= ies_q;
               cars_pkg::SEL_LINK: sreg_rdata_q <= link_q;
               cars_pkg::SEL_LOOP: sreg_rdata_q <= loop_q;
               cars_pkg::SEL_SAVE: sreg_rdata_q <= save_q;
               cars_pkg::SEL_IMPL0: sreg_rdata_q <= impl0_q;
               cars_pkg::SEL_TLO: sreg_rdata_q <= time_lower_q;
               cars_pkg::SEL_THI: sreg_rdata_q <= time_upper_q;
               default: sreg_rdata_q <= `CARS_WORD_RST;
            endcase
         end
      end
   end

   // Power state; sleep wins over nap, nap over doze
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pwr_state_q <= cars_pkg::PWR_FULL;
      end else begin
         case (pwr_state_q)
            cars_pkg::PWR_FULL: begin
               if (msw_q[`CARS_MSW_LOWE] && pwr_idle && !any_exc) begin
                  if (impl0_q[`CARS_IMPL_SLEEP]) begin
                     pwr_state_q <= cars_pkg::PWR_SLEEP;
                  end else if (impl0_q[`CARS_IMPL_NAP]) begin
                     pwr_state_q <= cars_pkg::PWR_NAP;
                  end else if (impl0_q[`CARS_IMPL_DOZE]) begin
                     pwr_state_q <= cars_pkg::PWR_DOZE;
                  end
               end
            end
            default: begin
               if (wake_evt) begin
                  pwr_state_q <= cars_pkg::PWR_FULL;
               end
            end
         endcase
      end
   end

   // Monitor marking and the async enable gate
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mark_count_q <= 1'b0;
         async_take_q <= 5'h00;
      end else begin
         mark_count_q <= msw_q[`CARS_MSW_MARK];
         async_take_q <= async_src & {5{msw_q[`CARS_MSW_AIE]}};
      end
   end

   // Memory traffic never passes here: no load or store port exists.
   // That keeps computation register-only.

   a_illegal_num: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (sreg_req && sreg_decode(sreg_num, sreg_wr) == cars_pkg::SEL_NONE)
      |=> (sreg_illegal_q && sreg_done_q && sreg_rdata_q == 32'h00000000))
      else $error("unknown register number not flagged");

   a_ies_store: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (sreg_req && sreg_wr && sreg_num == `CARS_SREG_IES && !ies_ca_we
       && !ies_ov_we)
      |=> ies_q[15:8] == $past(sreg_wdata[15:8]))
      else $error("status bits 16-23 not stored");

   a_tb_user_wr: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (sreg_req && sreg_wr && msw_q[`CARS_MSW_USER] &&
       (sreg_num == `CARS_SREG_TLO_WR || sreg_num == `CARS_SREG_THI_WR))
      |=> sreg_priv_q && !sreg_illegal_q)
      else $error("user write to time base not refused");

   a_exc_save: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (exc_take || call_take) |=> save_q == $past(msw_q))
      else $error("state word not saved on exception");

   a_pwr_gate: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (pwr_state_q == cars_pkg::PWR_FULL && !msw_q[`CARS_MSW_LOWE])
      |=> pwr_state_q == cars_pkg::PWR_FULL)
      else $error("power saving entered while disabled");

   a_wake_clear: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (pwr_state_q != cars_pkg::PWR_FULL && wake_evt && !msw_wr &&
       !ret_exec)
      |=> (pwr_state_q == cars_pkg::PWR_FULL &&
           !msw_q[`CARS_MSW_LOWE]))
      else $error("wake did not clear low-energy bit");

   a_async_mask: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !msw_q[`CARS_MSW_AIE] |=> async_take_q == 5'h00)
      else $error("masked source passed");

   a_loop_dec: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (loop_dec && !(sreg_req && sreg_wr && sreg_num == `CARS_SREG_LOOP))
      |=> loop_q == $past(loop_q) - 32'h00000001)
      else $error("loop count did not decrement");

endmodule : cars_regset

// *** dv/cars_regset_bench.sv ***
`timescale 1ns/1ps
`include "cars_cfg.svh"

module cars_regset_bench;
   typedef struct packed {
      logic rd_chk;
      logic [31:0] rd;
      logic ill;
      logic priv;
   } cars_exp_s;

   logic core_clk = 1'b0, rstn = 1'b0, gen_we = 1'b0, flt_we = 1'b0;
   logic cond_we = 1'b0, ies_ca_we = 1'b0, ies_ca_val = 1'b0;
   logic ies_ov_we = 1'b0, ies_ov_val = 1'b0, link_we = 1'b0;
   logic loop_dec = 1'b0, sreg_req = 1'b0, sreg_wr = 1'b0, msw_wr = 1'b0;
   logic exc_take = 1'b0, call_take = 1'b0, ret_exec = 1'b0;
   logic tb_tick = 1'b0, pwr_idle = 1'b0, wake_evt = 1'b0;
   logic [4:0] gen_ra = 5'h00, gen_rb = 5'h00, gen_rd = 5'h00;
   logic [4:0] flt_ra = 5'h00, flt_rb = 5'h00, flt_rd = 5'h00;
   logic [4:0] cond_bit_sel = 5'h00, async_src = 5'h00;
   logic [2:0] cond_fld = 3'h0;
   logic [3:0] cond_val = 4'h0;
   logic [9:0] sreg_num = 10'h000;
   logic [31:0] gen_wdata = 32'h0, link_addr = 32'h0;
   logic [31:0] sreg_wdata = 32'h0, msw_wdata = 32'h0;
   logic [63:0] flt_wdata = 64'h0;
   logic [31:0] gen_a_q, gen_b_q, cond_q, ies_q, link_q, loop_q, msw_q;
   logic [31:0] sreg_rdata_q, save_q, time_lower_q, time_upper_q;
   logic [63:0] flt_a_q, flt_b_q;
   logic [4:0] async_take_q;
   logic cond_bit_q, sreg_done_q, sreg_illegal_q, sreg_priv_q, mark_count_q;
   cars_pkg::cars_pwr_e pwr_state_q;
   int error_cnt = 0, num_checks = 0, cyc_cnt = 0;
   logic [31:0] seed = 32'hC54F75C3;
   cars_exp_s exp_q[$];
   cars_exp_s e_mon;
   logic [31:0] gm [32];
   logic [63:0] fm [32];

   cars_regset cars_regset_inst (
      .core_clk(core_clk), .rstn(rstn), .gen_ra(gen_ra), .gen_rb(gen_rb),
      .gen_we(gen_we), .gen_rd(gen_rd), .gen_wdata(gen_wdata),
      .gen_a_q(gen_a_q), .gen_b_q(gen_b_q), .flt_ra(flt_ra),
      .flt_rb(flt_rb), .flt_we(flt_we), .flt_rd(flt_rd),
      .flt_wdata(flt_wdata), .flt_a_q(flt_a_q), .flt_b_q(flt_b_q),
      .cond_we(cond_we), .cond_fld(cond_fld), .cond_val(cond_val),
      .cond_bit_sel(cond_bit_sel), .cond_q(cond_q), .cond_bit_q(cond_bit_q),
      .ies_ca_we(ies_ca_we), .ies_ca_val(ies_ca_val),
      .ies_ov_we(ies_ov_we), .ies_ov_val(ies_ov_val), .ies_q(ies_q),
      .link_we(link_we), .link_addr(link_addr), .loop_dec(loop_dec),
      .link_q(link_q), .loop_q(loop_q), .sreg_req(sreg_req),
      .sreg_wr(sreg_wr), .sreg_num(sreg_num), .sreg_wdata(sreg_wdata),
      .sreg_done_q(sreg_done_q), .sreg_rdata_q(sreg_rdata_q),
      .sreg_illegal_q(sreg_illegal_q), .sreg_priv_q(sreg_priv_q),
      .msw_wr(msw_wr), .msw_wdata(msw_wdata), .exc_take(exc_take),
      .call_take(call_take), .ret_exec(ret_exec), .msw_q(msw_q),
      .save_q(save_q), .tb_tick(tb_tick), .time_lower_q(time_lower_q),
      .time_upper_q(time_upper_q), .pwr_idle(pwr_idle),
      .wake_evt(wake_evt), .pwr_state_q(pwr_state_q),
      .mark_count_q(mark_count_q), .async_src(async_src),
      .async_take_q(async_take_q)
   );

   // Free-running 50 MHz clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   // Move request; req stays up so calls can run back to back
   task automatic mv(input logic wr, input logic [9:0] num,
                     input logic [31:0] wd, input logic rc,
                     input logic [31:0] rd, input logic ill, input logic pv);
      @(posedge core_clk);
      sreg_req <= 1'b1;
      sreg_wr <= wr;
      sreg_num <= num;
      sreg_wdata <= wd;
      exp_q.push_back({rc, rd, ill, pv});
   endtask : mv

   task automatic mvend();
      @(posedge core_clk);
      sreg_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask : mvend

   // Move-to-state also answers on the move bus, with no read data
   task automatic setmsw(input logic [31:0] v, input logic pv);
      @(posedge core_clk);
      msw_wr <= 1'b1;
      msw_wdata <= v;
      exp_q.push_back({1'b0, 32'h0, 1'b0, pv});
      @(posedge core_clk);
      msw_wr <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask : setmsw

   // Result watcher: every done pulse consumes the oldest expectation
   always @(posedge core_clk) begin
      if (rstn === 1'b1 && sreg_done_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1, 0);
         end else begin
            e_mon = exp_q.pop_front();
            chk(sreg_illegal_q, e_mon.ill);
            chk(sreg_priv_q, e_mon.priv);
            if (e_mon.rd_chk) chk(sreg_rdata_q, e_mon.rd);
         end
      end
   end

   // Hang guard; the full run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 6000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      logic [31:0] r, ce, a;
      cars_pkg::cars_pwr_e st;
      ce = 32'h0;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(msw_q, 32'h0);
      chk(pwr_state_q, cars_pkg::PWR_FULL);
      chk(cond_q, 32'h0);
      // Fill both register files, then read two ports at once
      for (int i = 0; i < 32; i++) begin
         gm[i] = rnd();
         fm[i] = {rnd(), rnd()};
         @(posedge core_clk);
         gen_we <= 1'b1;
         gen_rd <= 5'(i);
         gen_wdata <= gm[i];
         flt_we <= 1'b1;
         flt_rd <= 5'(i);
         flt_wdata <= fm[i];
      end
      @(posedge core_clk);
      gen_we <= 1'b0;
      flt_we <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         @(posedge core_clk);
         gen_ra <= 5'(i);
         gen_rb <= 5'(31 - i);
         flt_ra <= 5'(i);
         flt_rb <= 5'(31 - i);
         @(posedge core_clk);
         #1;
         chk(gen_a_q, gm[i]);
         chk(gen_b_q, gm[31 - i]);
         chk(flt_a_q, fm[i]);
         chk(flt_b_q, fm[31 - i]);
      end
      // Each condition field is written on its own
      for (int n = 0; n < 8; n++) begin
         r = rnd();
         ce[31 - 4 * n -: 4] = r[3:0];
         @(posedge core_clk);
         cond_we <= 1'b1;
         cond_fld <= 3'(n);
         cond_val <= r[3:0];
      end
      @(posedge core_clk);
      cond_we <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         @(posedge core_clk);
         cond_bit_sel <= r[4:0];
         @(posedge core_clk);
         #1;
         chk(cond_q, ce);
         chk(cond_bit_q, ce[31 - r[4:0]]);
      end
      // Back-to-back moves, refused numbers and time base writes
      r = rnd();
      mv(1, `CARS_SREG_IES, r, 0, 0, 0, 0);
      mv(0, `CARS_SREG_IES, 0, 1, r & `CARS_IES_MASK, 0, 0);
      mv(1, `CARS_SREG_LOOP, 32'h5, 0, 0, 0, 0);
      mv(1, 10'h3FF, r, 0, 0, 1, 0);
      mv(0, 10'h002, 0, 0, 0, 1, 0);
      mv(0, `CARS_SREG_TLO_WR, 0, 0, 0, 1, 0);
      mv(1, `CARS_SREG_TLO_RD, r, 0, 0, 1, 0);
      mv(1, `CARS_SREG_TLO_WR, 32'hFFFFFFFF, 0, 0, 0, 0);
      mv(1, `CARS_SREG_THI_WR, 32'h5, 0, 0, 0, 0);
      mv(1, `CARS_SREG_IES, 32'h0, 0, 0, 0, 0);
      mvend();
      r = rnd();
      @(posedge core_clk);
      loop_dec <= 1'b1;
      link_we <= 1'b1;
      link_addr <= r;
      ies_ov_we <= 1'b1;
      ies_ov_val <= 1'b1;
      tb_tick <= 1'b1;
      @(posedge core_clk);
      link_we <= 1'b0;
      ies_ov_we <= 1'b0;
      ies_ca_we <= 1'b1;
      ies_ca_val <= 1'b1;
      tb_tick <= 1'b0;
      @(posedge core_clk);
      loop_dec <= 1'b0;
      ies_ca_we <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(loop_q, 32'h3);
      chk(link_q, r);
      chk(ies_q, 32'hE0000000);
      chk(time_lower_q, 32'h0);
      chk(time_upper_q, 32'h6);
      mv(0, `CARS_SREG_LINK, 0, 1, r, 0, 0);
      mv(0, `CARS_SREG_LOOP, 0, 1, 32'h3, 0, 0);
      mvend();
      // User mode with async enable and marked process set
      setmsw(32'h0000C004, 1'b0);
      chk(msw_q, 32'h0000C004);
      a = rnd();
      @(posedge core_clk);
      async_src <= a[4:0];
      @(posedge core_clk);
      #1;
      chk(mark_count_q, 1'b1);
      chk(async_take_q, a[4:0]);
      mv(0, `CARS_SREG_THI_RD, 0, 1, 32'h6, 0, 0);
      mv(0, `CARS_SREG_IES, 0, 1, 32'hE0000000, 0, 0);
      mv(1, `CARS_SREG_THI_WR, 32'h1, 0, 0, 0, 1);
      mv(0, `CARS_SREG_SAVE, 0, 0, 0, 0, 1);
      mv(1, `CARS_SREG_IMPL0, 32'h0, 0, 0, 0, 1);
      mvend();
      // Move-to-state from user level is refused and changes nothing
      setmsw(32'h00000000, 1'b1);
      chk(msw_q, 32'h0000C004);
      @(posedge core_clk);
      exc_take <= 1'b1;
      @(posedge core_clk);
      exc_take <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(save_q, 32'h0000C004);
      chk(msw_q, 32'h00000004);
      chk(async_take_q, 5'h00);
      @(posedge core_clk);
      ret_exec <= 1'b1;
      @(posedge core_clk);
      ret_exec <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(msw_q, 32'h0000C004);
      @(posedge core_clk);
      call_take <= 1'b1;
      @(posedge core_clk);
      call_take <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(msw_q, 32'h00000004);
      mv(0, `CARS_SREG_SAVE, 0, 1, 32'h0000C004, 0, 0);
      mv(1, `CARS_SREG_THI_WR, 32'h7, 0, 0, 0, 0);
      mv(0, `CARS_SREG_THI_RD, 0, 1, 32'h7, 0, 0);
      mv(1, `CARS_SREG_LINK, ~r, 0, 0, 0, 0);
      mv(0, `CARS_SREG_LINK, 0, 1, ~r, 0, 0);
      mv(0, `CARS_SREG_TLO_RD, 0, 1, 32'h0, 0, 0);
      mv(1, `CARS_SREG_SAVE, r, 0, 0, 0, 0);
      mv(0, `CARS_SREG_SAVE, 0, 1, r, 0, 0);
      mvend();
      // Each low-power selection bit, entry and wake
      for (int b = 21; b < 24; b++) begin
         st = (b == 21) ? cars_pkg::PWR_SLEEP :
              (b == 22) ? cars_pkg::PWR_NAP : cars_pkg::PWR_DOZE;
         mv(1, `CARS_SREG_IMPL0, 32'h1 << b, 0, 0, 0, 0);
         mv(0, `CARS_SREG_IMPL0, 0, 1, 32'h1 << b, 0, 0);
         mvend();
         @(posedge core_clk);
         pwr_idle <= 1'b1;
         repeat (2) @(posedge core_clk);
         #1;
         chk(pwr_state_q, cars_pkg::PWR_FULL);
         setmsw(32'h00040000, 1'b0);
         @(posedge core_clk);
         #1;
         chk(pwr_state_q, st);
         @(posedge core_clk);
         pwr_idle <= 1'b0;
         wake_evt <= 1'b1;
         @(posedge core_clk);
         wake_evt <= 1'b0;
         @(posedge core_clk);
         #1;
         chk(pwr_state_q, cars_pkg::PWR_FULL);
         chk(msw_q[`CARS_MSW_LOWE], 1'b0);
      end
      chk(mark_count_q, 1'b0);
      repeat (3) @(posedge core_clk);
      chk(exp_q.size(), 0);
      results();
   end
endmodule : cars_regset_bench
